// File: bench/hesx_exec_tb.sv
// Self-checking testbench for the enter, increase, skip and stop unit.
`include "hesx_map.svh"
`timescale 1ns/100ps
`default_nettype none
module hesx_exec_tb;
	import hesx_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sw = 1'b0;
	logic rs = 1'b0;
	hesx_instr_t ins = '0;
	hesx_regs_t regs;
	hesx_seq_t seq;
	logic busy;
	int n_errors = 0;
	int checks = 0;

	always #2.5 clk = ~clk;

	hesx_exec DUT
	(
		.i_ref_clk(clk),
		.i_reset_n(rst_n),
		.i_instr(ins),
		.i_select_stop_sw(sw),
		.i_restart(rs),
		.o_regs(regs),
		.o_seq(seq),
		.o_busy(busy)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [23:0] sx(input logic [14:0] y);
		return {{9{y[14]}}, y};
	endfunction

	// End-around carry is folded back once; it cannot carry again.
	function automatic logic [23:0] oc(input logic [23:0] a,
		input logic [23:0] b);
		logic [24:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[23:0] + {23'h000000, s[24]};
	endfunction

	function automatic logic [23:0] wd(input logic [5:0] o,
		input logic [2:0] s, input logic [14:0] y);
		return {o, s, y};
	endfunction

	task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Holds the request until it is taken, then waits for completion.
	task automatic exec(input logic [23:0] w, input logic [14:0] p);
		int n;
		logic tk;
		@(negedge clk);
		ins <= '{valid: 1'b1, addr: p, word: w};
		n = 0;
		tk = 1'b0;
		while (!tk && n < 50)
		begin
			#1 tk = (busy === 1'b0);
			@(posedge clk);
			n++;
		end
		chk_bit(tk, 1'b1);
		@(negedge clk);
		ins.valid <= 1'b0;
		n = 0;
		while (seq.valid !== 1'b1 && seq.halted !== 1'b1 && n < 8)
		begin
			@(negedge clk);
			n++;
		end
		chk_bit(n < 8, 1'b1);
	endtask

	task automatic skip(input logic [23:0] w, input logic sk);
		exec(w, 15'h0200);
		chk_val({9'h000, seq.next_addr}, sk ? 24'h000202 : 24'h000201);
	endtask

	task automatic stop_run(input logic [23:0] w, input logic [14:0] p,
		input logic [14:0] nxt);
		int n;
		exec(w, p);
		repeat (4) @(negedge clk);
		chk_bit(seq.halted, 1'b1);
		chk_bit(busy, 1'b1);
		rs <= 1'b1;
		@(negedge clk);
		rs <= 1'b0;
		n = 0;
		while (seq.halted !== 1'b0 && n < 10)
		begin
			@(negedge clk);
			n++;
		end
		chk_bit(seq.halted, 1'b0);
		chk_val({9'h000, seq.next_addr}, {9'h000, nxt});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// The halt word is always plain: no indirect or indexed form.
	task automatic t_stop();
		stop_run(wd(`HESX_OP_HALT, 3'h0, 15'h1234), 15'h0010, 15'h1234);
		sw = 1'b1;
		stop_run({`HESX_OP_EXT, `HESX_EXT_SLS, 12'h000}, 15'h0020, 15'h0021);
		sw = 1'b0;
		exec({`HESX_OP_EXT, `HESX_EXT_SLS, 12'h000}, 15'h0030);
		chk_bit(seq.halted, 1'b0);
		chk_val({9'h000, seq.next_addr}, 24'h000031);
		stop_run({`HESX_OP_EXT, `HESX_EXT_UCS, 12'h000}, 15'h0040, 15'h0041);
	endtask

	task automatic t_enter();
		exec(wd(`HESX_OP_ENTER, `HESX_SUB_A, 15'h4001), 15'h0050);
		chk_val(regs.accum, 24'h004001);
		exec(wd(`HESX_OP_ENTER, `HESX_SUB_AS, 15'h4001), 15'h0051);
		chk_val(regs.accum, 24'hFFC001);
		exec(wd(`HESX_OP_ENTER, `HESX_SUB_Q, 15'h7FFF), 15'h0052);
		chk_val(regs.q, 24'h007FFF);
		exec(wd(`HESX_OP_ENTER, `HESX_SUB_QS, 15'h7FFF), 15'h0053);
		chk_val(regs.q, 24'hFFFFFF);
		exec({`HESX_OP_ENTER_CHAR_ADDRESS_OP, 1'b0, 17'h1ABCD}, 15'h0054);
		chk_val(regs.accum, 24'h01ABCD);
		exec({`HESX_OP_ENTER_CHAR_ADDRESS_OP, 1'b1, 17'h1ABCD}, 15'h0055);
		chk_val(regs.accum, 24'hFFABCD);
		exec({`HESX_OP_ENTER_CHAR_ADDRESS_OP, 1'b1, 17'h0ABCD}, 15'h0056);
		chk_val(regs.accum, 24'h00ABCD);
	endtask

	task automatic t_incr();
		exec(wd(`HESX_OP_ENTER, `HESX_SUB_A, 15'h6DB7), 15'h0060);
		exec(wd(`HESX_OP_INCR, `HESX_SUB_AS, 15'h7FF0), 15'h0061);
		chk_val(regs.accum, 24'h006DA8);
		exec(wd(`HESX_OP_INCR, `HESX_SUB_A, 15'h7FF0), 15'h0062);
		chk_val(regs.accum, oc(24'h006DA8, 24'h007FF0));
		exec(wd(`HESX_OP_INCR, `HESX_SUB_Q, 15'h0001), 15'h0063);
		chk_val(regs.q, 24'h000001);
		exec(wd(`HESX_OP_INCR, `HESX_SUB_QS, 15'h7FFD), 15'h0064);
		chk_val(regs.q, oc(24'h000001, sx(15'h7FFD)));
	endtask

	task automatic t_index();
		exec(wd(`HESX_OP_ENTER, 3'h1, 15'h7FFE), 15'h0070);
		skip(wd(`HESX_OP_SKEQ, 3'h1, 15'h7FFE), 1'b1);
		skip(wd(`HESX_OP_SKEQ, 3'h1, 15'h7FFD), 1'b0);
		exec(wd(`HESX_OP_INCR, 3'h1, 15'h0001), 15'h0071);
		skip(wd(`HESX_OP_SKEQ, 3'h1, 15'h7FFF), 1'b1);
		skip(wd(`HESX_OP_SKGE, 3'h1, 15'h0005), 1'b1);
		exec(wd(`HESX_OP_ENTER, 3'h2, 15'h0003), 15'h0072);
		skip(wd(`HESX_OP_SKGE, 3'h2, 15'h0004), 1'b0);
		skip(wd(`HESX_OP_SKGE, 3'h2, 15'h0003), 1'b1);
		exec(wd(`HESX_OP_ENTER, 3'h0, 15'h0005), 15'h0073);
		exec(wd(`HESX_OP_INCR, 3'h0, 15'h0005), 15'h0074);
		skip(wd(`HESX_OP_SKEQ, 3'h0, 15'h0000), 1'b1);
		skip(wd(`HESX_OP_SKEQ, 3'h0, 15'h0001), 1'b0);
		skip(wd(`HESX_OP_SKGE, 3'h0, 15'h0001), 1'b0);
		exec(wd(`HESX_OP_ENTER, 3'h3, 15'h0002), 15'h0075);
		skip(wd(`HESX_OP_ISKIP, 3'h3, 15'h0005), 1'b0);
		skip(wd(`HESX_OP_SKEQ, 3'h3, 15'h0003), 1'b1);
		skip(wd(`HESX_OP_ISKIP, 3'h3, 15'h0003), 1'b1);
		skip(wd(`HESX_OP_SKEQ, 3'h3, 15'h0000), 1'b1);
		exec(wd(`HESX_OP_ENTER, 3'h3, 15'h0004), 15'h0076);
		skip(wd(`HESX_OP_ISKIP, 3'h7, 15'h0006), 1'b0);
		skip(wd(`HESX_OP_SKEQ, 3'h3, 15'h0003), 1'b1);
		skip(wd(`HESX_OP_ISKIP, 3'h7, 15'h0003), 1'b1);
		skip(wd(`HESX_OP_SKEQ, 3'h3, 15'h0000), 1'b1);
		skip(wd(`HESX_OP_ISKIP, 3'h4, 15'h0000), 1'b1);
	endtask

	task automatic t_rskip();
		exec(wd(`HESX_OP_ENTER, `HESX_SUB_AS, 15'h4001), 15'h0080);
		skip(wd(`HESX_OP_SKEQ, `HESX_SUB_A, 15'h4001), 1'b1);
		skip(wd(`HESX_OP_SKEQ, `HESX_SUB_AS, 15'h4001), 1'b1);
		exec(wd(`HESX_OP_ENTER, `HESX_SUB_A, 15'h4001), 15'h0081);
		skip(wd(`HESX_OP_SKEQ, `HESX_SUB_AS, 15'h4001), 1'b0);
		skip(wd(`HESX_OP_SKEQ, `HESX_SUB_A, 15'h4002), 1'b0);
		exec(wd(`HESX_OP_ENTER, `HESX_SUB_QS, 15'h7FFF), 15'h0082);
		skip(wd(`HESX_OP_SKEQ, `HESX_SUB_Q, 15'h7FFF), 1'b1);
		skip(wd(`HESX_OP_SKEQ, `HESX_SUB_QS, 15'h7FFF), 1'b1);
		skip(wd(`HESX_OP_SKEQ, `HESX_SUB_QS, 15'h0000), 1'b0);
	endtask

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (2) @(negedge clk);
		rst_n <= 1'b1;
		repeat (3) @(negedge clk);
		t_stop();
		t_enter();
		t_incr();
		t_index();
		t_rskip();
		final_report();
	end

	// About fifty instructions of a few cycles each fit well inside this.
	initial
	begin
		#50000;
		n_errors++;
		final_report();
	end
endmodule // hesx_exec_tb
`default_nettype wire

// File: verilog/hesx_exec.sv
// Execution unit for halt, stop, enter, increase and skip instructions.
`include "hesx_map.svh"
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Halt with subfield zero stops; restart fetches from the halt word's address field.
// - Selective stop halts only with console switch set; restart at P+1.
// - Unconditional stop always halts; restart continues at P+1.
// - Enter index loads y into the chosen index; designator zero does nothing.
// - Subfield 6 loads y into A; subfield 4 loads sign-extended y.
// - Subfield 7 loads y into Q; subfield 5 loads sign-extended y.
// - Enter character address loads 17-bit z into A, upper bits zero.
// - Sign-extended form loads z with seven copies of its sign.
// - Sign comes from bit 14 of y, bit 16 of z.
// - Increase index adds y to the index; designator zero does nothing.
// - Increase adds y to A or Q, plain or sign-extended by subfield.
// - Index skip-equal goes to P+2 on match; zero designator compares zero.
// - A skip-equal compares only the lower 15 bits of A.
// - Sign-extended skip-equal compares all 24 bits with extended y.
// - Q skip-equal uses lower 15 bits of Q; subfield 5 extends.
// - Index skip-greater compares unsigned 15-bit values, skip when index >= y.
// - Incremental skip clears index on match and skips, else increments.
// - Decremental skip clears index on match and skips, else decrements.
module hesx_exec
	import hesx_pkg::*;
(
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// Instruction in.
	input wire hesx_instr_t i_instr,
	// Console.
	input wire logic i_select_stop_sw,
	input wire logic i_restart,
	// Results.
	output hesx_regs_t o_regs,
	output hesx_seq_t o_seq,
	output logic o_busy
);
	// ------------------------------------------------------------
	// Reset synchroniser.
	// ------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Decode.
	// ------------------------------------------------------------
	function automatic logic [23:0] sext15(input logic [14:0] v);
		sext15 = {{9{v[`HESX_Y_HI]}}, v};
	endfunction

	hesx_state_t state_q;
	logic [5:0] opc;
	logic [2:0] sub;
	logic [1:0] idx;
	logic [14:0] y;
	logic [16:0] z;
	logic [14:0] p1;
	logic [14:0] p2;
	logic go;
	// The index read is registered, so instructions that use it take a
	// second cycle; the first cycle only addresses the file.
	logic idx_op;
	logic phase_q;
	hesx_instr_t held_q;
	hesx_instr_t cur;
	assign cur = phase_q ? held_q : i_instr;
	assign opc = cur.word[`HESX_OP_HI:`HESX_OP_LO];
	assign sub = cur.word[`HESX_SUB_HI:`HESX_SUB_LO];
	assign idx = cur.word[`HESX_IDX_HI:`HESX_IDX_LO];
	assign y = cur.word[`HESX_Y_HI:0];
	assign z = cur.word[`HESX_Z_HI:0];
	assign p1 = cur.addr + 15'h0001;
	assign p2 = cur.addr + 15'h0002;
	// Bit 17 picks the decrementing index skip; bits 16:15 stay the
	// designator, so both index skips read the file.
	assign idx_op = (!sub[2] && (opc == `HESX_OP_ENTER
		|| opc == `HESX_OP_INCR || opc == `HESX_OP_SKEQ
		|| opc == `HESX_OP_SKGE)) || opc == `HESX_OP_ISKIP;
	assign go = (state_q == HESX_RUN) && (phase_q || (i_instr.valid
		&& !idx_op));
	assign o_busy = (state_q != HESX_RUN) || phase_q;

	always_ff @(posedge i_ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			phase_q <= 1'b0;
			held_q <= '0;
		end
		else if (phase_q)
			phase_q <= 1'b0;
		else if (state_q == HESX_RUN && i_instr.valid && idx_op)
		begin
			phase_q <= 1'b1;
			held_q <= i_instr;
		end
	end

	// ------------------------------------------------------------
	// Index file and adders.
	// ------------------------------------------------------------
	logic [14:0] bidx;
	logic idx_we;
	logic [14:0] idx_wd;
	hesx_index_file #(.W(15), .N(4)) u_idx (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(rst_n_q),
		.i_we(idx_we),
		.i_waddr(idx),
		.i_wdata(idx_wd),
		.i_raddr(i_instr.word[`HESX_IDX_HI:`HESX_IDX_LO]),
		.o_rdata(bidx)
	);

	logic [23:0] add_src;
	logic [23:0] add_opd;
	logic [23:0] add_sum;
	always_comb
	begin
		add_src = (sub == `HESX_SUB_Q || sub == `HESX_SUB_QS) ? o_regs.q
			: o_regs.accum;
		add_opd = sub[1] ? {9'h000, y} : sext15(y);
		if (!sub[2])
		begin
			add_src = sext15(bidx);
			add_opd = sext15(y);
		end
	end
	hesx_ones_add #(.W(24)) u_add (
		.i_a(add_src),
		.i_b(add_opd),
		.o_sum(add_sum)
	);

	// ------------------------------------------------------------
	// Compare.
	// ------------------------------------------------------------
	logic skip;
	logic [23:0] cmp_reg;
	always_comb
	begin
		cmp_reg = (sub == `HESX_SUB_Q || sub == `HESX_SUB_QS) ? o_regs.q
			: o_regs.accum;
		skip = 1'b0;
		case (opc)
			`HESX_OP_SKEQ:
				if (!sub[2])
					skip = (bidx == y);
				else if (sub[1])
					skip = (cmp_reg[14:0] == y);
				else
					skip = (cmp_reg == sext15(y));
			`HESX_OP_SKGE:
				if (!sub[2])
					skip = (bidx >= y);
				else if (sub[1])
					skip = (cmp_reg[14:0] >= y);
				else
					skip = ($signed(cmp_reg) >= $signed(sext15(y)));
			`HESX_OP_ISKIP:
				skip = (bidx == y);
			default:
				skip = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Index writes.
	// ------------------------------------------------------------
	always_comb
	begin
		idx_we = 1'b0;
		idx_wd = '0;
		if (go && (!sub[2] || opc == `HESX_OP_ISKIP)
			&& idx != 2'h0)
		begin
			case (opc)
				`HESX_OP_ENTER:
				begin
					idx_we = 1'b1;
					idx_wd = y;
				end
				`HESX_OP_INCR:
				begin
					idx_we = 1'b1;
					idx_wd = add_sum[14:0];
				end
				`HESX_OP_ISKIP:
				begin
					idx_we = 1'b1;
					if (skip)
						idx_wd = '0;
					else if (sub[2])
						idx_wd = bidx - 15'h0001;
					else
						idx_wd = bidx + 15'h0001;
				end
				default:
					idx_we = 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Accumulator and Q.
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			o_regs.accum <= `HESX_RST_WORD;
		else if (go)
		begin
			if (opc == `HESX_OP_ENTER_CHAR_ADDRESS_OP)
				o_regs.accum <= sub[2] ? {{7{z[`HESX_Z_HI]}}, z}
					: {7'h00, z};
			else if (opc == `HESX_OP_ENTER && sub == `HESX_SUB_A)
				o_regs.accum <= {9'h000, y};
			else if (opc == `HESX_OP_ENTER && sub == `HESX_SUB_AS)
				o_regs.accum <= sext15(y);
			else if (opc == `HESX_OP_INCR && (sub == `HESX_SUB_A
				|| sub == `HESX_SUB_AS))
				o_regs.accum <= add_sum;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			o_regs.q <= `HESX_RST_WORD;
		else if (go)
		begin
			if (opc == `HESX_OP_ENTER && sub == `HESX_SUB_Q)
				o_regs.q <= {9'h000, y};
			else if (opc == `HESX_OP_ENTER && sub == `HESX_SUB_QS)
				o_regs.q <= sext15(y);
			else if (opc == `HESX_OP_INCR && (sub == `HESX_SUB_Q
				|| sub == `HESX_SUB_QS))
				o_regs.q <= add_sum;
		end
	end

	// ------------------------------------------------------------
	// Sequencing and stops.
	// ------------------------------------------------------------
	logic stop_now;
	logic [14:0] nxt;
	always_comb
	begin
		stop_now = 1'b0;
		nxt = skip ? p2 : p1;
		if (opc == `HESX_OP_HALT && sub == 3'h0)
		begin
			stop_now = 1'b1;
			nxt = cur.word[14:0];
		end
		else if (opc == `HESX_OP_EXT && cur.word[17:12] == `HESX_EXT_SLS)
			stop_now = i_select_stop_sw;
		else if (opc == `HESX_OP_EXT && cur.word[17:12] == `HESX_EXT_UCS)
			stop_now = 1'b1;
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			state_q <= HESX_RUN;
		else
			case (state_q)
				HESX_RUN:
					if (go && stop_now)
						state_q <= HESX_STOP;
				HESX_STOP:
					if (i_restart)
						state_q <= HESX_RUN;
				default:
					state_q <= HESX_RUN;
			endcase
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			o_seq <= '0;
		else
		begin
			o_seq.valid <= (go && !stop_now)
				|| (state_q == HESX_STOP && i_restart);
			o_seq.halted <= (state_q == HESX_STOP && !i_restart)
				|| (go && stop_now);
			if (go)
				o_seq.next_addr <= nxt;
		end
	end

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	property p_halt_stops;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		(go && opc == `HESX_OP_HALT && sub == 3'h0)
			|=> (o_seq.halted && o_seq.next_addr == $past(cur.word[14:0]));
	endproperty
	a_halt_stops: assert property (p_halt_stops) else $error("halt");
	property p_ucs;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		(go && opc == `HESX_OP_EXT && cur.word[17:12] == `HESX_EXT_UCS)
			|=> (state_q == HESX_STOP && o_seq.next_addr == $past(p1));
	endproperty
	a_ucs: assert property (p_ucs) else $error("stop");
	property p_sls_off;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		(go && opc == `HESX_OP_EXT && cur.word[17:12] == `HESX_EXT_SLS
			&& !i_select_stop_sw) |=> state_q == HESX_RUN;
	endproperty
	a_sls_off: assert property (p_sls_off) else $error("sls");
	property p_ena;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		(go && opc == `HESX_OP_ENTER && sub == `HESX_SUB_AS)
			|=> o_regs.accum == sext15($past(y));
	endproperty
	a_ena: assert property (p_ena) else $error("ena");
	property p_enq;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		(go && opc == `HESX_OP_ENTER && sub == `HESX_SUB_Q)
			|=> o_regs.q == {9'h000, $past(y)};
	endproperty
	a_enq: assert property (p_enq) else $error("enq");
	property p_enter_char_address_op;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		(go && opc == `HESX_OP_ENTER_CHAR_ADDRESS_OP && !sub[2])
			|=> o_regs.accum[23:17] == 7'h00;
	endproperty
	a_enter_char_address_op: assert property (p_enter_char_address_op) else $error("enter_char_address_op");
	property p_skip;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		(go && skip && !stop_now) |=> o_seq.next_addr == $past(p2);
	endproperty
	a_skip: assert property (p_skip) else $error("skip");
	property p_noskip;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		(go && opc == `HESX_OP_SKEQ && sub == `HESX_SUB_A
			&& o_regs.accum[14:0] != y) |=> o_seq.next_addr == $past(p1);
	endproperty
	a_noskip: assert property (p_noskip) else $error("ase");
	property p_idx_zero;
		@(posedge i_ref_clk) disable iff (!rst_n_q)
		idx == 2'h0 |-> !idx_we;
	endproperty
	a_idx_zero: assert property (p_idx_zero) else $error("idx0");
endmodule // hesx_exec
`default_nettype wire

// File: verilog/hesx_index_file.sv
// Index register file with registered read data.
`timescale 1ns/100ps
`default_nettype none
module hesx_index_file #(
	parameter int W = 15,
	parameter int N = 4
)(
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Write port.
	input wire logic i_we,
	input wire logic [$clog2(N)-1:0] i_waddr,
	input wire logic [W-1:0] i_wdata,
	// Read port.
	input wire logic [$clog2(N)-1:0] i_raddr,
	output logic [W-1:0] o_rdata
);
	logic [W-1:0] mem [N];
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int k = 0; k < N; k++)
				mem[k] <= '0;
		end
		else if (i_we && i_waddr != '0)
			mem[i_waddr] <= i_wdata;
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rdata <= '0;
		else if (i_we && i_waddr == i_raddr && i_waddr != '0)
			o_rdata <= i_wdata;
		else
			o_rdata <= (i_raddr == '0) ? '0 : mem[i_raddr];
	end
endmodule // hesx_index_file
`default_nettype wire

// File: verilog/hesx_map.svh
// Field positions, opcodes and subfield codes for the enter/increase/skip unit.
`ifndef HESX_MAP_SVH
`define HESX_MAP_SVH
`define HESX_OP_HI 23
`define HESX_OP_LO 18
`define HESX_SUB_HI 17
`define HESX_SUB_LO 15
`define HESX_IDX_HI 16
`define HESX_IDX_LO 15
`define HESX_Y_HI 14
`define HESX_Z_HI 16
`define HESX_OP_HALT 6'h00
`define HESX_OP_SKEQ 6'h04
`define HESX_OP_SKGE 6'h05
`define HESX_OP_ISKIP 6'h08
`define HESX_OP_ENTER_CHAR_ADDRESS_OP 6'h09
`define HESX_OP_ENTER 6'h0C
`define HESX_OP_INCR 6'h0D
`define HESX_OP_EXT 6'h3F
`define HESX_SUB_A 3'h6
`define HESX_SUB_AS 3'h4
`define HESX_SUB_Q 3'h7
`define HESX_SUB_QS 3'h5
`define HESX_EXT_SLS 6'h3A
`define HESX_EXT_UCS 6'h3B
`define HESX_RST_WORD 24'h000000
`define HESX_RST_IDX 15'h0000
`endif

// File: verilog/hesx_ones_add.sv
// One's-complement adder with end-around carry.
`timescale 1ns/100ps
`default_nettype none
module hesx_ones_add #(
	parameter int W = 24
)(
	// Operands.
	input wire logic [W-1:0] i_a,
	input wire logic [W-1:0] i_b,
	// Sum.
	output logic [W-1:0] o_sum
);
	logic [W:0] raw;
	always_comb
	begin
		raw = {1'b0, i_a} + {1'b0, i_b};
		o_sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
	end
endmodule // hesx_ones_add
`default_nettype wire

// File: verilog/hesx_pkg.sv
// Types shared by the enter/increase/skip unit.
package hesx_pkg;
	typedef struct packed
	{
		logic [23:0] accum;
		logic [23:0] q;
	} hesx_regs_t;
	typedef struct packed
	{
		logic valid;
		logic [14:0] addr;
		logic [23:0] word;
	} hesx_instr_t;
	typedef struct packed
	{
		logic valid;
		logic halted;
		logic [14:0] next_addr;
	} hesx_seq_t;
	typedef enum logic [1:0] {HESX_RUN, HESX_STOP} hesx_state_t;
endpackage
